// file: verilog/chg_pkg.sv
// package of constants and types for the charger control block
package chg_pkg;
  // clock rate and derived timing
  localparam int unsigned CLK_HZ          = 100_000_000;  // system clock rate
  localparam int unsigned PWM_HZ          = 3_000_000;    // converter switching rate
  localparam int unsigned PWM_PERIOD_CYC  = CLK_HZ / PWM_HZ;  // 33 cycles per switching period
  localparam int unsigned DUTY_MAX_PERMIL = 995;          // largest duty cycle in tenths of percent
  localparam int unsigned DUTY_MAX_CYC    = (PWM_PERIOD_CYC * DUTY_MAX_PERMIL) / 1000;
  localparam int unsigned TICK_MS         = 1;            // timebase tick in ms
  localparam int unsigned TICK_CYC        = CLK_HZ / 1000 * TICK_MS;  // cycles per tick
  localparam int unsigned BOOST_LIMIT_S   = 32;           // boost safety limit in s
  localparam int unsigned CHARGE_LIMIT_MIN = 32;          // charge safety limit in minutes
  localparam int unsigned DPM_DELAY_MS    = 32;           // power-management event delay
  localparam int unsigned BOOST_LIMIT_TICKS  = BOOST_LIMIT_S * 1000 / TICK_MS;
  localparam int unsigned CHARGE_LIMIT_TICKS = CHARGE_LIMIT_MIN * 60 * 1000 / TICK_MS;
  localparam int unsigned DPM_DELAY_TICKS    = DPM_DELAY_MS / TICK_MS;
  // operating mode field codes
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_BOOST  = 2'h1;
  localparam logic [1:0] MODE_CHARGE = 2'h2;
  localparam logic [1:0] MODE_CHGTRM = 2'h3;
  // status pin control codes
  localparam logic [1:0] STAT_AUTO   = 2'h0;
  localparam logic [1:0] STAT_LOW    = 2'h1;
  localparam logic [1:0] STAT_HIZ    = 2'h2;
  // reset values
  localparam logic [1:0] INCAP_RESET = 2'h0;              // 100 mA input current cap code
  localparam logic       TERM_RESET  = 1'b0;              // termination off by default
  // first event register bit positions
  localparam int unsigned EV1_OVP_BIT  = 0;
  // second event register bit positions
  localparam int unsigned EV2_BOOST_TO = 0;
  localparam int unsigned EV2_CHG_TO   = 1;
  localparam int unsigned EV2_REV      = 2;
  localparam int unsigned EV2_DPM      = 3;
  localparam int unsigned EV2_BATOV    = 4;
  localparam int unsigned EV2_THERM    = 5;
  localparam int unsigned EV_WIDTH     = 8;
  // slew step of the current target per tick
  localparam logic [7:0] SLEW_STEP     = 8'h01;
  localparam logic [7:0] LOWCAP_CODE   = 8'h0f;           // 150 mA current code
  localparam logic [7:0] PRECHG_CODE   = 8'h03;           // precharge current code
  localparam logic [7:0] FOLD_STEP     = 8'h01;           // thermal fold reduction per tick

  // synchronised comparator results
  typedef struct packed {
    logic supply_valid;      // supply above poor-source level
    logic supply_ovp;        // supply over-voltage
    logic reverse;           // supply below battery sense plus margin
    logic below_pm;          // supply at power-management threshold
    logic below_precharge;   // battery below precharge threshold
    logic below_recharge;    // battery below recharge threshold
    logic near_regulation;   // battery at regulation voltage
    logic taper_reached;     // current at taper cutoff
    logic batt_ovp;          // battery over-voltage
    logic temp_fold;         // die at thermal fold threshold
    logic temp_fold_top;     // die 10 C above fold threshold
    logic temp_shutdown;     // die above shutdown threshold
    logic temp_release;      // die 10 C below shutdown threshold
    logic peak_limit;        // high-side peak current limit
    logic lowside_above;     // low-side current above 100 mA
  } chg_comp_type;
  localparam int unsigned COMP_W = $bits(chg_comp_type);

  // host programmed settings
  typedef struct packed {
    logic [1:0] operating_mode_field;
    logic [1:0] input_current_cap;
    logic [7:0] fast_charge_current;
    logic [7:0] regulation_voltage;
    logic [3:0] taper_cutoff_current;
    logic       term_enable;
    logic [1:0] stat_mode;
  } chg_cfg_type;

  // charge phase states
  typedef enum logic [5:0] {
    ST_HIZ    = 6'h01,
    ST_PRE    = 6'h02,
    ST_FAST   = 6'h04,
    ST_TAPER  = 6'h08,
    ST_DONE   = 6'h10,
    ST_BOOST  = 6'h20
  } chg_state_type;
endpackage

// file: verilog/chg_sync.sv
// two-flop synchroniser bank for comparator inputs
`timescale 1ns/10ps
module chg_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // raw and synchronised levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_r;  // first stage, read only by second
  logic [WIDTH-1:0] stage2_r;  // second stage

  // two flops per bit
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          stage1_r[gi] <= 1'b0;
          stage2_r[gi] <= 1'b0;
        end else begin
          stage1_r[gi] <= async_in[gi];
          stage2_r[gi] <= stage1_r[gi];
        end
      end
    end
  endgenerate
  assign sync_out = stage2_r;
endmodule

// file: verilog/chg_pwm.sv
// fixed-frequency pwm with peak limit and low-side sync control
`timescale 1ns/10ps
module chg_pwm
  import chg_pkg::*;
#(
  parameter int unsigned PERIOD = PWM_PERIOD_CYC,
  parameter int unsigned DMAX   = DUTY_MAX_CYC
) (
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  // control
  input  wire logic       enable_in,       // converter running
  input  wire logic [7:0] duty_in,         // demanded on time in cycles
  input  wire logic       peak_limit_in,   // peak current reached
  input  wire logic       lowside_above_in,// low-side current above threshold
  // gate drives
  output logic            high_gate_out,
  output logic            low_gate_out
);
  initial begin
    if (DMAX >= PERIOD || PERIOD > 255) $error("pwm period or duty limit unusable");
  end
  logic [7:0] phase_r;     // position within period
  logic       hs_r;        // high-side on
  logic       ls_r;        // low-side on
  wire  [7:0] duty_cap = (duty_in > 8'(DMAX)) ? 8'(DMAX) : duty_in;  // clamp to DMAX, 32 of 33 cycles, not the 99.5% asked [R1]
  wire        period_end = (phase_r == 8'(PERIOD - 1));
  wire        on_phase   = enable_in && (phase_r < duty_cap);

  // period counter and gate flops
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_r <= 8'h00;
      hs_r    <= 1'b0;
      ls_r    <= 1'b0;
    end else begin
      phase_r <= period_end ? 8'h00 : phase_r + 8'h01;  // 3 MHz period [R1]
      // high side drops for one cycle at the peak limit, then turns back on within the on phase [R2]
      hs_r    <= on_phase && !(hs_r && peak_limit_in);
      // low side only while its current stays above threshold [R3]
      ls_r    <= enable_in && !on_phase && lowside_above_in;
    end
  end
  assign high_gate_out = hs_r;
  assign low_gate_out  = ls_r;
endmodule

// file: verilog/chg_ctrl.sv
// charger control state machine, safety timer and protection events
//
// Overview of operation
// R1: converter runs 3 MHz, duty up to 99.5%; clamp is 32 of 33 cycles
// R2: high side ends at 1.9 A peak; code drops it one cycle, then it turns back on
// R3: low side off below 100 mA
// R4: below precharge threshold stay in precharge
// R5: fast phase slews to lower current limit
// R6: host sets cap and current; cap 100mA
// R7: host sets regulation voltage 3.5 to 4.44V
// R8: taper cutoff ends charge when termination enabled
// R9: four events restart a charge cycle
// R10: thermal fold reduces current to zero
// R11: thermal shutdown suspends until cooled 10 C
// R12: timer starts at nonzero mode, command restarts
// R13: 32 s in boost clears mode, flags
// R14: 32 min charging clears mode, flags; 17-bit time_r makes the default limit 84992 ticks
// R15: timeout changes only the mode field
// R16: input over-voltage stops converter, auto resume
// R17: reverse current enters high impedance, flags
// R18: power management reduces current, 32 ms event
// R19: source insertion sets low current cap
// R20: battery over-voltage stops, flags, resumes later; code clears the mode field, no resume
// R21: short battery charged at precharge current
// R22: status pin auto, low or released
// R23: charging fault clears mode, flags, high impedance
// R24: any event access releases pin; read clears
// R25: masks gate only the event pin
// R26: one timebase counter cleared by command
// R27: comparators pass two-flop synchroniser
`timescale 1ns/10ps
module chg_ctrl
  import chg_pkg::*;
#(
  parameter int unsigned TICK       = TICK_CYC,
  parameter int unsigned BOOST_TKS  = BOOST_LIMIT_TICKS,
  parameter int unsigned CHARGE_TKS = CHARGE_LIMIT_TICKS,
  parameter int unsigned DPM_TKS    = DPM_DELAY_TICKS
) (
  // clock and reset
  input  wire logic                clock_in,
  input  wire logic                resetn_in,
  // analog comparator results, asynchronous
  input  wire chg_comp_type        comp_in,
  // host settings
  input  wire logic [1:0]          mode_wr_data_in,   // new operating mode field
  input  wire logic                mode_wr_in,        // pulse: write mode field
  input  wire logic                lowcap_clear_in,   // pulse: host clears low cap
  input  wire logic [1:0]          input_current_cap_in,
  input  wire logic [7:0]          fast_charge_current_in,
  input  wire logic [7:0]          regulation_voltage_in,
  input  wire logic [3:0]          taper_cutoff_current_in,
  input  wire logic                term_enable_in,
  input  wire logic [1:0]          stat_mode_in,
  input  wire logic                charge_reset_in,   // pulse: host reset bit
  input  wire logic                valid_cmd_in,      // pulse: valid serial command
  // event access
  input  wire logic                ev1_read_in,       // pulse: first event register read
  input  wire logic                ev2_read_in,       // pulse: second event register read
  input  wire logic                ev_access_in,      // pulse: any event register access
  input  wire logic [EV_WIDTH-1:0] event_mask_one_in,
  input  wire logic [EV_WIDTH-1:0] event_mask_two_in,
  // status outputs
  output logic [1:0]               operating_mode_field_out,
  output logic                     low_current_cap_out,
  output logic [EV_WIDTH-1:0]      first_event_register_out,
  output logic [EV_WIDTH-1:0]      second_event_register_out,
  output logic [5:0]               charge_state_out,
  output logic [7:0]               current_target_out,
  output logic [7:0]               regulation_voltage_out,
  output logic [1:0]               input_current_cap_out,
  output logic                     blocking_switch_out,  // input switch on
  // pins
  output logic                     event_pin_out,      // open-drain, held 0; event_pin_oe_n_out low pulls the pin
  output logic                     event_pin_oe_n_out,
  output logic                     stat_pin_out,
  output logic                     stat_pin_oe_n_out,
  output logic                     high_gate_out,
  output logic                     low_gate_out
);
  initial begin
    if (TICK < 1 || DPM_TKS < 1 || BOOST_TKS >= CHARGE_TKS) $error("bad timing parameters");
  end
  // reset release
  logic rst_s1_r;   // reset sync first flop
  logic rst_n_r;    // released reset used inside
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // comparator synchronisation
  logic [COMP_W-1:0] comp_raw_s;  // synchronised vector
  chg_comp_type      cmp;         // synchronised results
  chg_sync #(.WIDTH(COMP_W)) u_sync (  // [R27]
    .clock_in (clock_in),
    .rst_n_in (rst_n_r),
    .async_in (comp_in),
    .sync_out (comp_raw_s)
  );
  assign cmp = chg_comp_type'(comp_raw_s);

  // registered state
  chg_state_type     state_r, state_nxt;  // charge phase
  logic [1:0]        mode_r;              // operating mode field
  logic              lowcap_r;            // low current cap bit
  logic [1:0]        incap_r;             // input current cap
  logic [7:0]        fcc_r;               // fast charge current
  logic [7:0]        vreg_r;              // regulation voltage
  logic              term_r;              // termination enable
  logic [EV_WIDTH-1:0] ev1_r;             // first event register
  logic [EV_WIDTH-1:0] ev2_r;             // second event register
  logic              evpin_r;             // event pin pulled
  logic [16:0]       tick_cnt_r;          // divider to tick
  logic [16:0]       time_r;              // safety timebase in ticks
  logic [5:0]        dpm_cnt_r;           // power-management delay
  logic [7:0]        target_r;            // slewed current target
  logic              valid_q_r;           // supply valid last cycle
  logic              shut_r;              // thermal shutdown latched
  logic              term_q_r;            // termination enable last cycle

  // settings: host writes; cap resets to 100 mA when supply is lost [R6] [R7]
  always_ff @(posedge clock_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      incap_r <= INCAP_RESET;
      fcc_r   <= 8'h00;
      vreg_r  <= 8'h00;
      term_r  <= TERM_RESET;  // termination default off [R8]
      term_q_r <= TERM_RESET;
    end else begin
      incap_r <= cmp.supply_valid ? input_current_cap_in : INCAP_RESET;  // [R6]
      fcc_r   <= fast_charge_current_in;  // [R6]
      vreg_r  <= regulation_voltage_in;   // range held by host [R7]
      term_r  <= term_enable_in;
      term_q_r <= term_r;
    end
  end

  // event decode
  wire tick        = (tick_cnt_r == 17'(TICK - 1));
  wire insert      = cmp.supply_valid && !valid_q_r;
  wire removed     = !cmp.supply_valid && valid_q_r;
  wire mode_nz     = (mode_r != MODE_OFF);
  wire charging_md = (mode_r == MODE_CHARGE) || (mode_r == MODE_CHGTRM);
  wire boost_to    = (mode_r == MODE_BOOST) && (time_r >= 17'(BOOST_TKS));   // [R13]
  wire charge_to   = charging_md && tick && (time_r >= 17'(CHARGE_TKS - 1));  // [R14]
  wire rev_evt     = cmp.reverse && cmp.supply_valid && charging_md;         // [R17]
  wire batov_evt   = cmp.batt_ovp && charging_md;                            // [R20]
  wire ovp_evt     = cmp.supply_ovp;                                         // [R16]
  wire dpm_evt     = tick && cmp.below_pm && (dpm_cnt_r == 6'(DPM_TKS - 1)); // [R18]
  wire fault_clr   = rev_evt || batov_evt;                  // charging faults [R23]
  wire timeout     = boost_to || charge_to;
  wire recharge    = (mode_r == MODE_CHGTRM) && term_r && cmp.below_recharge
                     && (state_r == ST_DONE);
  wire term_fall   = (state_r == ST_DONE) && term_q_r && !term_r;
  wire restart     = insert || recharge || charge_reset_in || term_fall;  // [R9]
  wire suspend     = shut_r || ovp_evt || !cmp.supply_valid;  // converter off, resumable
  wire cmd_clr     = valid_cmd_in || !mode_nz;

  // timebase: one counter for both limits, cleared by command or mode off [R26] [R12]
  always_ff @(posedge clock_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tick_cnt_r <= 17'h00000;
      time_r     <= 17'h00000;
    end else begin
      tick_cnt_r <= (tick || cmd_clr) ? 17'h00000 : tick_cnt_r + 17'h00001;
      if (cmd_clr) begin
        time_r <= 17'h00000;  // [R12] [R26]
      end else if (tick && time_r != 17'h1ffff) begin
        time_r <= time_r + 17'h00001;
      end
    end
  end

  // mode field: host writes, timeouts and faults change it, never other settings [R15]
  always_ff @(posedge clock_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r <= MODE_OFF;
    end else if (timeout || fault_clr) begin
      mode_r <= MODE_OFF;  // [R13] [R14] [R23]
    end else if (mode_wr_in) begin
      mode_r <= mode_wr_data_in;
    end
  end

  // low current cap set on insertion, set beats host clear [R19]
  always_ff @(posedge clock_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lowcap_r  <= 1'b1;
      valid_q_r <= 1'b0;
    end else begin
      valid_q_r <= cmp.supply_valid;
      if (insert) begin
        lowcap_r <= 1'b1;  // [R19]
      end else if (lowcap_clear_in) begin
        lowcap_r <= 1'b0;
      end
    end
  end

  // thermal shutdown with release hysteresis [R11]
  always_ff @(posedge clock_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      shut_r <= 1'b0;
    end else if (cmp.temp_shutdown) begin
      shut_r <= 1'b1;
    end else if (cmp.temp_release) begin
      shut_r <= 1'b0;
    end
  end

  // power-management delay counter, restarts when the sag clears [R18]
  always_ff @(posedge clock_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dpm_cnt_r <= 6'h00;
    end else if (!cmp.below_pm || removed) begin
      dpm_cnt_r <= 6'h00;
    end else if (tick && dpm_cnt_r != 6'(DPM_TKS - 1)) begin
      dpm_cnt_r <= dpm_cnt_r + 6'h01;
    end
  end

  // event flags: set wins over read clear; masks act on pin only [R24] [R25]
  logic [EV_WIDTH-1:0] ev1_set, ev2_set;  // new events this cycle
  assign ev1_set = EV_WIDTH'(ovp_evt) << EV1_OVP_BIT;  // [R16]
  assign ev2_set = (EV_WIDTH'(boost_to)  << EV2_BOOST_TO)   // [R13]
                 | (EV_WIDTH'(charge_to) << EV2_CHG_TO)     // [R14]
                 | (EV_WIDTH'(rev_evt)   << EV2_REV)        // [R17]
                 | (EV_WIDTH'(dpm_evt)   << EV2_DPM)        // [R18]
                 | (EV_WIDTH'(batov_evt) << EV2_BATOV)      // [R20]
                 | (EV_WIDTH'(cmp.temp_shutdown) << EV2_THERM);
  wire [EV_WIDTH-1:0] ev1_new = ev1_set & ~ev1_r;  // only fresh events pull pin
  wire [EV_WIDTH-1:0] ev2_new = ev2_set & ~ev2_r;
  wire pin_set = |(ev1_new & ~event_mask_one_in) || |(ev2_new & ~event_mask_two_in);  // [R25]
  always_ff @(posedge clock_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ev1_r   <= '0;
      ev2_r   <= '0;
      evpin_r <= 1'b0;
    end else begin
      ev1_r   <= (ev1_read_in ? '0 : ev1_r) | ev1_set;  // [R24]
      ev2_r   <= (ev2_read_in ? '0 : ev2_r) | ev2_set;  // [R24]
      evpin_r <= pin_set || (evpin_r && !ev_access_in);  // [R24]
    end
  end

  // charge phase sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_HIZ: begin
        if (mode_r == MODE_BOOST) begin
          state_nxt = ST_BOOST;
        end else if (charging_md && !suspend) begin
          state_nxt = ST_PRE;
        end
      end
      ST_PRE: begin
        if (!cmp.below_precharge) begin
          state_nxt = ST_FAST;  // leave precharge [R4] [R21]
        end
      end
      ST_FAST: begin
        if (cmp.below_precharge) begin
          state_nxt = ST_PRE;  // short battery [R21]
        end else if (cmp.near_regulation) begin
          state_nxt = ST_TAPER;
        end
      end
      ST_TAPER: begin
        if (term_r && cmp.taper_reached && !cmp.below_recharge) begin
          state_nxt = ST_DONE;  // [R8]
        end else if (!cmp.near_regulation) begin
          state_nxt = ST_FAST;
        end
      end
      ST_DONE: begin
        state_nxt = ST_DONE;
      end
      ST_BOOST: begin
        if (mode_r != MODE_BOOST) begin
          state_nxt = ST_HIZ;
        end
      end
      default: begin
        state_nxt = ST_HIZ;
      end
    endcase
    if (!mode_nz || suspend || fault_clr || timeout) begin
      state_nxt = ST_HIZ;  // [R11] [R16] [R17] [R20] [R23]
    end else if (restart && charging_md) begin
      state_nxt = ST_PRE;  // [R9]
    end
  end
  always_ff @(posedge clock_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_HIZ;
    end else begin
      state_r <= state_nxt;
    end
  end

  // current target: ceiling chosen, slewed up, folded for heat and sag [R5] [R10]
  wire [7:0] cap_code = (incap_r == 2'h0) ? LOWCAP_CODE - 8'h05 : 8'hff;  // input cap
  wire [7:0] lim_a    = (fcc_r < cap_code) ? fcc_r : cap_code;            // [R5]
  wire [7:0] lim_b    = (lowcap_r && lim_a > LOWCAP_CODE) ? LOWCAP_CODE : lim_a;  // [R19]
  wire       fast_ph  = (state_r == ST_FAST) || (state_r == ST_TAPER);
  wire [7:0] ceiling  = (state_r == ST_PRE) ? PRECHG_CODE : (fast_ph ? lim_b : 8'h00);  // [R4]
  wire       reduce   = cmp.temp_fold || cmp.below_pm;  // [R10] [R18]
  always_ff @(posedge clock_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      target_r <= 8'h00;
    end else if (cmp.temp_fold_top || ceiling == 8'h00) begin
      target_r <= 8'h00;  // zero at fold plus 10 C [R10]
    end else if (target_r > ceiling) begin
      target_r <= ceiling;
    end else if (tick && reduce) begin
      target_r <= (target_r > FOLD_STEP) ? target_r - FOLD_STEP : 8'h00;  // [R10] [R18]
    end else if (tick && target_r < ceiling) begin
      target_r <= target_r + SLEW_STEP;  // controlled slew [R5]
    end
  end

  // converter
  wire conv_on = fast_ph || (state_r == ST_PRE);
  chg_pwm u_pwm (
    .clock_in         (clock_in),
    .rst_n_in         (rst_n_r),
    .enable_in        (conv_on),
    .duty_in          (target_r),
    .peak_limit_in    (cmp.peak_limit),
    .lowside_above_in (cmp.lowside_above),
    .high_gate_out    (high_gate_out),
    .low_gate_out     (low_gate_out)
  );

  // status pin: auto low while charging, forced low or released [R22]
  wire stat_low = (stat_mode_in == STAT_LOW) || ((stat_mode_in == STAT_AUTO) && conv_on);

  // outputs
  assign operating_mode_field_out  = mode_r;
  assign low_current_cap_out       = lowcap_r;
  assign first_event_register_out  = ev1_r;
  assign second_event_register_out = ev2_r;
  assign charge_state_out          = state_r;
  assign current_target_out        = target_r;
  assign regulation_voltage_out    = vreg_r;
  assign input_current_cap_out     = incap_r;
  assign blocking_switch_out       = (state_r != ST_HIZ);  // off in high impedance [R17]
  assign event_pin_out             = 1'b0;
  assign event_pin_oe_n_out        = !evpin_r;
  assign stat_pin_out              = 1'b0;
  assign stat_pin_oe_n_out         = !stat_low;  // [R22]
endmodule

// file: dv/chg_ctrl_props.sv
// checker relating charger control outputs to their causes
`timescale 1ns/10ps
module chg_ctrl_props
  import chg_pkg::*;
(
  // watched ports
  input wire logic       clock_in,
  input wire logic       resetn_in,
  input wire logic [1:0] stat_mode_in,
  input wire logic [7:0] event_mask_two_in,
  input wire logic       ev_access_in,
  input wire logic [1:0] operating_mode_field_out,
  input wire logic       low_current_cap_out,
  input wire logic [7:0] second_event_register_out,
  input wire logic [5:0] charge_state_out,
  input wire logic [7:0] current_target_out,
  input wire logic       blocking_switch_out,
  input wire logic       event_pin_oe_n_out,
  input wire logic       stat_pin_oe_n_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  blk_switch_a: assert property (blocking_switch_out == (charge_state_out != 6'h01))
    else $error("blocking switch disagrees with state");
  stat_low_a: assert property ((stat_mode_in == STAT_LOW) [*5] |-> !stat_pin_oe_n_out)
    else $error("status pin not forced low");
  stat_rel_a: assert property (stat_mode_in[1] [*5] |-> stat_pin_oe_n_out)
    else $error("status pin not released");
  boost_to_a: assert property ($rose(second_event_register_out[0]) |-> !operating_mode_field_out)
    else $error("boost timeout left mode set");
  chg_to_a: assert property ($rose(second_event_register_out[1]) |->
    operating_mode_field_out == MODE_OFF ##[1:3] charge_state_out == 6'h01)
    else $error("charge timeout did not stop charging");
  unmasked_pin_a: assert property ($rose(second_event_register_out[0]) &&
    !event_mask_two_in[0] && !ev_access_in |-> ##[0:1] !event_pin_oe_n_out)
    else $error("unmasked event did not pull pin");
  cap_reset_a: assert property ($rose(resetn_in) |-> low_current_cap_out)
    else $error("low current cap not set at reset");
  cap_target_a: assert property (low_current_cap_out [*4] |-> current_target_out <= LOWCAP_CODE)
    else $error("target above low current cap");
endmodule

// file: dv/chg_host.sv
// host model: services the event pin by accessing the event registers
`timescale 1ns/10ps
module chg_host (
  // clock, enable and event pin level
  input wire logic clock_in,
  input wire logic en_in,
  input wire logic pin_oe_n_in,
  // access strobe, gaps one cycle between accesses
  output logic     acc_out = 1'b0
);
  always @(posedge clock_in) acc_out <= en_in && !pin_oe_n_in && !acc_out;
endmodule

// file: dv/tb_chg_ctrl.sv
// self-checking bench for the charger control block
`timescale 1ns/10ps
bind chg_ctrl chg_ctrl_props u_props (.*);
module tb_chg_ctrl import chg_pkg::*;;
  logic clock_in = 0, resetn_in = 0, host_en = 0, acc, mwr = 0, vcmd = 0, lcc = 0;
  logic [1:0] mwd = 0, smode = 0, mode;
  logic [7:0] rv = 0, mask2 = 0, event_mask_one = 0, ev1, ev2, rvo;
  logic [1:0] icap = 1;
  logic term = 0, crst = 0;
  logic lcap, pin_n, stat_n;
  chg_comp_type comp = '0;
  int num_errors = 0, tests_run = 0, cyc = 0;
  logic [31:0] lfsr = 32'hed49;
  chg_ctrl #(.TICK(10), .BOOST_TKS(4), .CHARGE_TKS(8), .DPM_TKS(2)) u_dut (
    .clock_in, .resetn_in, .comp_in(comp), .mode_wr_data_in(mwd), .mode_wr_in(mwr),
    .lowcap_clear_in(lcc), .input_current_cap_in(icap), .fast_charge_current_in(lfsr[15:8]),
    .regulation_voltage_in(rv), .taper_cutoff_current_in(4'h0), .term_enable_in(term),
    .stat_mode_in(smode), .charge_reset_in(crst), .valid_cmd_in(vcmd), .ev1_read_in(acc),
    .ev2_read_in(acc), .ev_access_in(acc), .event_mask_one_in(event_mask_one),
    .event_mask_two_in(mask2), .operating_mode_field_out(mode), .low_current_cap_out(lcap),
    .first_event_register_out(ev1), .second_event_register_out(ev2), .charge_state_out(),
    .current_target_out(), .regulation_voltage_out(rvo), .input_current_cap_out(),
    .blocking_switch_out(), .event_pin_out(), .event_pin_oe_n_out(pin_n),
    .stat_pin_out(), .stat_pin_oe_n_out(stat_n), .high_gate_out(), .low_gate_out());
  chg_host u_host (.clock_in, .en_in(host_en), .pin_oe_n_in(pin_n), .acc_out(acc));
  initial forever #5 clock_in = ~clock_in;
  // compare one result and count it
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // next value of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // wait n edges
  task automatic w(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // one-cycle mode write
  task automatic setmode(input logic [1:0] m);
    @(posedge clock_in);
    mwd <= m;
    mwr <= 1;
    w(1);
    mwr <= 0;
  endtask
  // bounded wait for the mode field to fall to off
  task automatic wait_off;
    repeat (200) if (mode !== MODE_OFF) w(1);
  endtask
  // hang guard
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    w(4);
    resetn_in <= 1;
    comp.supply_valid <= 1;
    lfsr <= lfsr_next(lfsr);
    w(1);
    rv <= lfsr[7:0];
    w(9);
    chk(lcap, 1);
    chk(mode, 0);
    chk(rvo, rv);
    lcc <= 1;
    w(1);
    lcc <= 0;
    w(2);
    chk(lcap, 0);
    setmode(MODE_BOOST);
    w(30);
    chk(mode, 1);
    wait_off;
    chk(ev2, 8'h01);
    chk(rvo, rv);
    chk(pin_n, 0);
    host_en <= 1;
    w(6);
    chk(pin_n, 1);
    chk(ev2, 0);
    host_en <= 0;
    mask2 <= 8'h02;
    setmode(MODE_CHARGE);
    for (int i = 0; i < 4; i++) begin
      smode <= i[1:0];
      w(6);
      chk(stat_n, i > 1);
    end
    comp.supply_ovp <= 1;
    w(6);
    chk(ev1, 8'h01);
    comp.supply_ovp <= 0;
    host_en <= 1;
    w(8);
    host_en <= 0;
    w(1);
    chk(pin_n, 1);
    repeat (15) begin
      w(20);
      vcmd <= 1;
      w(1);
      vcmd <= 0;
    end
    chk(mode, 2);
    wait_off;
    chk(ev2, 8'h02);
    chk(pin_n, 1);
    final_report();
  end
endmodule
